// ==== src/dtc_top.sv ====
module dtc_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // clock sources and power mode
    input  wire logic        fast_tick,
    input  wire logic        slow_tick,
    input  wire logic        divider_stage_select,
    input  wire logic        low_speed_mode,
    // event pins
    input  wire logic [1:0]  event_pin,
    // outputs
    output logic [1:0]       divider_out_pin,
    output logic [1:0]       match_irq
);
    ////////////////////////////////////////////////////////////////////////
    dtc_pkg::dtc_ctrl_s ctrl_ff [2];
    logic [7:0]  cmp_ff [2];
    logic [7:0]  cnt_ff [2];
    logic [1:0]  tff_ff;
    logic [1:0]  ev_s1_ff, ev_s2_ff, ev_s3_ff;
    logic [10:0] fc_pre_ff;
    logic [2:0]  fs_pre_ff;
    logic        ack_ff;
    logic        fc_d7, fc_d5, fc_d3, fc_d1, fs_d3;
    logic [1:0]  tick, hit, fall;
    logic [1:0]  ctrl_wr;
    logic        cascade;
    logic [15:0] cnt16, cmp16;

    // select a tick from the clock select code
    function automatic logic pick_tick(input logic [2:0] sel,
                                       input logic pin_fall);
        logic slowest;
        // carry pulse only: the prescaler holds all ones for a whole period
        slowest = divider_stage_select ? fs_d3
                                       : fast_tick && fc_pre_ff == '1; // [RULE16]
        if (low_speed_mode) begin
            // only slow sources and the event pin while fast clock is down
            unique case (sel) // [RULE13]
                dtc_pkg::CK_SLOWEST: pick_tick = fs_d3;
                dtc_pkg::CK_FS:      pick_tick = slow_tick;
                dtc_pkg::CK_PIN:     pick_tick = pin_fall;
                default:             pick_tick = 1'b0;
            endcase
        end else begin
            unique case (sel)
                dtc_pkg::CK_SLOWEST: pick_tick = slowest;
                dtc_pkg::CK_FC_D7:   pick_tick = fc_d7;
                dtc_pkg::CK_FC_D5:   pick_tick = fc_d5;
                dtc_pkg::CK_FC_D3:   pick_tick = fc_d3;
                dtc_pkg::CK_FS:      pick_tick = slow_tick;
                dtc_pkg::CK_FC_D1:   pick_tick = fc_d1;
                dtc_pkg::CK_FC:      pick_tick = fast_tick;
                default:             pick_tick = pin_fall;
            endcase
        end
    endfunction : pick_tick

    ////////////////////////////////////////////////////////////////////////
    // prescalers on fast and slow tick enables
    always_ff @(posedge clock) begin
        if (reset) begin
            fc_pre_ff <= '0;
            fs_pre_ff <= '0;
        end else begin
            if (fast_tick)
                fc_pre_ff <= fc_pre_ff + 11'h001;
            if (slow_tick)
                fs_pre_ff <= fs_pre_ff + 3'h1;
        end
    end

    // stage carry pulses
    always_comb begin
        fc_d7 = fast_tick && fc_pre_ff[6:0] == 7'h7f;
        fc_d5 = fast_tick && fc_pre_ff[4:0] == 5'h1f;
        fc_d3 = fast_tick && fc_pre_ff[2:0] == 3'h7;
        fc_d1 = fast_tick && fc_pre_ff[0];
        fs_d3 = slow_tick && fs_pre_ff == 3'h7;
    end

    ////////////////////////////////////////////////////////////////////////
    // event pin synchroniser and falling edge detect
    always_ff @(posedge clock) begin
        if (reset) begin
            ev_s1_ff <= 2'h3;
            ev_s2_ff <= 2'h3;
            ev_s3_ff <= 2'h3;
        end else begin
            ev_s1_ff <= event_pin;
            ev_s2_ff <= ev_s1_ff;
            ev_s3_ff <= ev_s2_ff;
        end
    end

    assign fall = ev_s3_ff & ~ev_s2_ff; // [RULE21]

    ////////////////////////////////////////////////////////////////////////
    // cascade and per-counter tick / match
    always_comb begin
        cascade = ctrl_ff[1].mode[2]; // [RULE15] [RULE18]
        cnt16   = {cnt_ff[1], cnt_ff[0]};
        cmp16   = {cmp_ff[1], cmp_ff[0]};
        // lower select drives both halves in 16-bit mode
        tick[0] = pick_tick(ctrl_ff[0].clk_sel, fall[0]); // [RULE14]
        tick[1] = cascade ? tick[0]
                          : pick_tick(ctrl_ff[1].clk_sel, fall[1]);
        if (cascade) begin
            hit[1] = ctrl_ff[1].run && tick[0] && cnt16 == cmp16;
            hit[0] = 1'b0;
        end else begin
            for (int i = 0; i < 2; i++)
                hit[i] = ctrl_ff[i].run && tick[i] && cnt_ff[i] == cmp_ff[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counters
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_ff[0] <= '0;
            cnt_ff[1] <= '0;
        end else if (cascade) begin
            if (!ctrl_ff[1].run)
                {cnt_ff[1], cnt_ff[0]} <= '0; // [RULE19]
            else if (hit[1])
                {cnt_ff[1], cnt_ff[0]} <= '0;
            else if (tick[0])
                {cnt_ff[1], cnt_ff[0]} <= cnt16 + 16'h0001;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ctrl_ff[i].run)
                    cnt_ff[i] <= '0; // [RULE19]
                else if (hit[i])
                    cnt_ff[i] <= '0; // [RULE1] [RULE2] [RULE4]
                else if (tick[i])
                    cnt_ff[i] <= cnt_ff[i] + 8'h01; // [RULE1] [RULE2]
            end
        end
    end

    // one-cycle match interrupt
    always_ff @(posedge clock) begin
        if (reset)
            match_irq <= '0;
        else
            match_irq <= hit; // [RULE22]
    end

    ////////////////////////////////////////////////////////////////////////
    // accepted control writes, one per counter
    always_comb begin
        ctrl_wr[0] = write && ack_ff && byteenable[0]
                     && address == dtc_pkg::OFF_CTRL_LO;
        ctrl_wr[1] = write && ack_ff && byteenable[0]
                     && address == dtc_pkg::OFF_CTRL_HI;
    end

    // toggle flop and divider pin
    // flop loads only from writes made while stopped (start write too),
    // so the write that stops a running counter leaves the pin level alone
    always_ff @(posedge clock) begin
        if (reset) begin
            tff_ff <= '0; // [RULE6]
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ctrl_wr[i] && !ctrl_ff[i].run)
                    tff_ff[i] <= writedata[dtc_pkg::BIT_FLOP]; // [RULE6] [RULE9]
                else if (hit[i] && ctrl_ff[i].mode == dtc_pkg::dtc_m_div)
                    tff_ff[i] <= ~tff_ff[i]; // [RULE4]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset)
            divider_out_pin <= 2'h3;
        else
            divider_out_pin <= ~tff_ff; // [RULE5] [RULE10]
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then ack
    always_ff @(posedge clock) begin
        if (reset)
            ack_ff <= 1'b0;
        else
            ack_ff <= (read || write) && !ack_ff;
    end

    assign waitrequest = !ack_ff;

    // register writes, compare takes effect at once
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_ff[0] <= dtc_pkg::CTRL_RST;
            ctrl_ff[1] <= dtc_pkg::CTRL_RST;
            cmp_ff[0]  <= dtc_pkg::CMP_RST;
            cmp_ff[1]  <= dtc_pkg::CMP_RST;
        end else if (write && ack_ff && byteenable[0]) begin
            unique case (address)
                dtc_pkg::OFF_CTRL_LO: ctrl_ff[0] <= writedata[7:0]; // [RULE10]
                dtc_pkg::OFF_CTRL_HI: ctrl_ff[1] <= writedata[7:0];
                dtc_pkg::OFF_CMP_LO:  cmp_ff[0]  <= writedata[7:0]; // [RULE7]
                dtc_pkg::OFF_CMP_HI:  cmp_ff[1]  <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // read data registered at the ack edge
    always_ff @(posedge clock) begin
        if (reset)
            readdata <= '0;
        else if (read && !ack_ff) begin
            unique case (address)
                dtc_pkg::OFF_CTRL_LO: readdata <= {24'h0, ctrl_ff[0]};
                dtc_pkg::OFF_CTRL_HI: readdata <= {24'h0, ctrl_ff[1]};
                dtc_pkg::OFF_CMP_LO:  readdata <= {24'h0, cmp_ff[0]};
                dtc_pkg::OFF_CMP_HI:  readdata <= {24'h0, cmp_ff[1]};
                default:              readdata <= '0;
            endcase
        end
    end
endmodule : dtc_top

// ==== src/dtc_pkg.sv ====
// Overview of operation
// [RULE1] timer mode: count ticks; on match pulse irq, clear, keep counting
// [RULE2] event mode: count falling pin edges, on match pulse irq and clear
// [RULE3] event input levels held two machine cycles each by the source
// [RULE4] divider mode: match toggles flop, clears counter, pulses irq
// [RULE5] divider output pin is the inverse of the toggle flop
// [RULE6] toggle flop loaded from control bit 7; reset clears it to zero
// [RULE7] compare value not double buffered; writes act immediately
// [RULE8] software keeps flop bit zero in timer and event modes
// [RULE9] stopped divider holds pin level; change flop bit only after stop
// [RULE10] run bit is bit 3, flop bit bit 7; clearing bit 7 drives pin high
// [RULE11] compare values 1..255 for 8-bit, 1..65535 for 16-bit modes
// [RULE12] warm-up, 16-bit modulation and pulse gen limits kept by software
// [RULE13] low speed modes limit timer sources to slow clock divided by 8; the code also passes the undivided slow clock on CK_FS
// [RULE14] 16-bit modes take clock select from the lower counter
// [RULE15] both counters cascade into one 16-bit counter
// [RULE16] slowest tick is fast/2048 or slow/8 by divider stage select
// [RULE17] software sets port output latch before using divider output
// [RULE18] mode field: 000 timer/event, 001 divider, 1xx 16-bit modes
// [RULE19] clearing run bit stops and clears; setting starts counting
// [RULE20] software changes mode, clock and flop bits only with start write
// [RULE21] event input sampled and falling edge found from two samples
// [RULE22] match irq is a one-cycle pulse in the tick the counter clears
package dtc_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] OFF_CTRL_LO = 4'h0;
    localparam logic [3:0] OFF_CMP_LO  = 4'h4;
    localparam logic [3:0] OFF_CTRL_HI = 4'h8;
    localparam logic [3:0] OFF_CMP_HI  = 4'hc;
    // control register fields
    localparam int BIT_FLOP = 7;
    localparam int BIT_RUN  = 3;
    localparam int CK_LSB   = 4;
    localparam int MODE_LSB = 0;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST  = 8'hff;
    // clock select codes
    localparam logic [2:0] CK_SLOWEST = 3'h0;
    localparam logic [2:0] CK_FC_D7   = 3'h1;
    localparam logic [2:0] CK_FC_D5   = 3'h2;
    localparam logic [2:0] CK_FC_D3   = 3'h3;
    localparam logic [2:0] CK_FS      = 3'h4;
    localparam logic [2:0] CK_FC_D1   = 3'h5;
    localparam logic [2:0] CK_FC      = 3'h6;
    localparam logic [2:0] CK_PIN     = 3'h7;
    // divider stage lengths
    localparam int FC_SLOW_DIV = 2048;
    localparam int FS_SLOW_DIV = 8;
    localparam int PRE_W       = 11;
    // mode field codes
    typedef enum logic [2:0] {
        dtc_m_timer  = 3'h0,
        dtc_m_div    = 3'h1,
        dtc_m_pwm8   = 3'h2,
        dtc_m_rsv    = 3'h3,
        dtc_m_t16    = 3'h4,
        dtc_m_warm   = 3'h5,
        dtc_m_pwm16  = 3'h6,
        dtc_m_ppg    = 3'h7
    } dtc_mode_e;
    // decoded control byte
    typedef struct packed {
        logic      flop_initial_bit;
        logic [2:0] clk_sel;
        logic      run;
        dtc_mode_e mode;
    } dtc_ctrl_s;
endpackage : dtc_pkg

// ==== verification/dtc_sva.sv ====
module dtc_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // bus
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // outputs
    input wire logic [1:0]  divider_out_pin,
    input wire logic [1:0]  match_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic [3:0] wr_age_ff;
    // cycles since the last write request
    always_ff @(posedge clock) begin
        if (reset || write) wr_age_ff <= 4'h0;
        else if (wr_age_ff != 4'hf) wr_age_ff <= wr_age_ff + 4'h1;
    end
    // request taken, then a one-cycle answer
    sequence s_req; (read || write) && waitrequest; endsequence
    sequence s_ack; !waitrequest; endsequence
    a_bus_answer: assert property (s_req |=> s_ack)
        else $error("request not answered next cycle");
    a_ack_single: assert property (s_ack |=> waitrequest)
        else $error("waitrequest low too long");
    a_rdata_zero: assert property (readdata[31:8] == 24'h0)
        else $error("readdata upper bits set");
    a_irq_lo_pulse: assert property (match_irq[0] |=> !match_irq[0])
        else $error("lower irq longer than one cycle");
    a_irq_hi_pulse: assert property (match_irq[1] |=> !match_irq[1])
        else $error("upper irq longer than one cycle");
    a_reset_pin: assert property (disable iff (1'b0)
        reset ##1 reset |=> divider_out_pin == 2'b11)
        else $error("divider pin low in reset");
    a_reset_irq: assert property (disable iff (1'b0)
        reset ##1 reset |-> match_irq == 2'b00)
        else $error("irq during reset");
    a_pin_cause: assert property ($changed(divider_out_pin) |->
        $past(match_irq) != 2'b00 || wr_age_ff < 4'h8)
        else $error("divider pin moved without match or write");
endmodule : dtc_sva
////////////////////////////////////////////////////////////////
bind dtc_top dtc_sva dtc_sva_inst (.clock, .reset, .read, .write,
    .readdata, .waitrequest, .divider_out_pin, .match_irq);

// ==== verification/dtc_partner.sv ====
module dtc_partner (
    // clock and request
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [7:0] pulses,
    // event pins
    output logic      [1:0] event_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial event_pin = 2'b11;
    // pulse train, each level held four cycles
    always @(posedge go) begin
        repeat (pulses) begin
            repeat (4) @(posedge clock);
            event_pin <= 2'b00;
            repeat (4) @(posedge clock);
            event_pin <= 2'b11;
        end
    end
endmodule : dtc_partner

// ==== verification/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, reset = 1, read = 0, write = 0, go = 0;
    logic [3:0]  address = 4'h0, byteenable = 4'hf;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic        waitrequest, fast_tick = 0, slow_tick = 0;
    logic        divider_stage_select = 0, low_speed_mode = 0;
    logic [1:0]  event_pin, divider_out_pin, match_irq;
    logic [7:0]  pulses = 8'h0;
    int          n_mismatch = 0, checks_done = 0, cyc = 0, seed = 2;
    int          irq_t[2][$];
    int          n1 = 0, c;
    dtc_top dtc_top_inst (.clock, .reset, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .fast_tick,
        .slow_tick, .divider_stage_select, .low_speed_mode, .event_pin,
        .divider_out_pin, .match_irq);
    dtc_partner dtc_partner_inst (.clock, .go, .pulses, .event_pin);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////
    // tick sources, irq model log and timeout
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fast_tick <= ~fast_tick;
        slow_tick <= (cyc % 8 == 7);
        if (match_irq[0] === 1'b1) irq_t[0].push_back(cyc);
        if (match_irq[1] === 1'b1) irq_t[1].push_back(cyc);
        if (match_irq[1] === 1'b1) n1 <= n1 + 1;
        if (cyc > 60000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task stop_test();
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task cmp(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %0h got %0h", what, exp, got);
        end
    endtask : cmp
    // one avalon transfer, held until waitrequest low
    task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= {24'h0, d};
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    function automatic logic [7:0] ctl(logic f, logic [2:0] k, logic r,
                                       logic [2:0] m);
        return {f, k, r, m};
    endfunction : ctl
    // cycles between the second and third match
    task per(input int ch, input int exp);
        irq_t[ch].delete();
        while (irq_t[ch].size() < 3) @(posedge clock);
        cmp("period", exp, irq_t[ch][2] - irq_t[ch][1]);
    endtask : per
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        bus(4'h0, 0, 0); cmp("ctrl_rst", dtc_pkg::CTRL_RST, q);
        bus(4'h4, 0, 0); cmp("cmp_rst", dtc_pkg::CMP_RST, q);
        bus(4'h2, 0, 0); cmp("unmapped", 0, q);
        cmp("pin_rst", 2'b11, divider_out_pin);
        c = 1 + {$random(seed)} % 16;
        bus(4'h4, 1, c[7:0]); bus(4'h4, 0, 0);
        cmp("cmp_rd", c, q);
        bus(4'h0, 1, ctl(0, dtc_pkg::CK_FC, 1, 3'h0));
        per(0, 2 * (c + 1));
        low_speed_mode <= 1'b1;
        repeat (4) @(posedge clock);
        irq_t[0].delete();
        repeat (200) @(posedge clock);
        cmp("no_tick", 0, irq_t[0].size());
        bus(4'h0, 1, 8'h00);
        divider_stage_select <= 1'b1;
        bus(4'h0, 1, ctl(0, dtc_pkg::CK_SLOWEST, 1, 3'h0));
        per(0, 64 * (c + 1));
        bus(4'h0, 1, 8'h00);
        low_speed_mode <= 1'b0;
        divider_stage_select <= 1'b0;
        bus(4'h4, 1, 8'h01);
        bus(4'h0, 1, ctl(0, dtc_pkg::CK_SLOWEST, 1, 3'h0));
        per(0, 2 * dtc_pkg::FC_SLOW_DIV * 2);
        c = 1 + {$random(seed)} % 6;
        bus(4'h0, 1, 8'h00);
        bus(4'h4, 1, c[7:0]);
        bus(4'h0, 1, ctl(0, dtc_pkg::CK_PIN, 1, 3'h0));
        irq_t[0].delete();
        pulses <= 8'(2 * (c + 1));
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (16 * (c + 1) + 20) @(posedge clock);
        cmp("events", 2, irq_t[0].size());
        bus(4'h0, 1, 8'h00);
        c = 1 + {$random(seed)} % 16;
        bus(4'hc, 1, c[7:0]);
        bus(4'h8, 1, ctl(1, dtc_pkg::CK_FC, 1, 3'h1));
        per(1, 2 * (c + 1));
        repeat (c + 1) @(posedge clock);
        cmp("pin_div", n1[0], divider_out_pin[1]);
        bus(4'h8, 1, ctl(1, dtc_pkg::CK_FC, 0, 3'h1));
        repeat (40) @(posedge clock);
        cmp("pin_hold", n1[0], divider_out_pin[1]);
        bus(4'h8, 1, ctl(0, dtc_pkg::CK_FC, 0, 3'h1));
        repeat (4) @(posedge clock);
        cmp("pin_clr", 1, divider_out_pin[1]);
        bus(4'hc, 1, 8'h01); bus(4'h4, 1, 8'h02);
        bus(4'h0, 1, ctl(0, dtc_pkg::CK_FC, 0, 3'h3));
        bus(4'h8, 1, ctl(0, dtc_pkg::CK_SLOWEST, 1, 3'h4));
        irq_t[0].delete();
        per(1, 2 * 259);
        cmp("lo_quiet", 0, irq_t[0].size());
        stop_test();
    end
endmodule : tb
